// ---- smfc_pkg.sv ----
// constants for the sideband multicast and flow control command block
`default_nettype none
package smfc_pkg;
    // ----------------------------------------
    // command and response type codes
    // ----------------------------------------
    localparam logic [7:0] CMD_EN_GMCAST = 8'h12;
    localparam logic [7:0] CMD_DIS_GMCAST = 8'h13;
    localparam logic [7:0] CMD_SET_FC = 8'h14;
    localparam logic [7:0] CMD_GET_VER = 8'h15;
    localparam logic [7:0] RSP_EN_GMCAST = 8'h92;
    localparam logic [7:0] RSP_DIS_GMCAST = 8'h93;
    localparam logic [7:0] RSP_SET_FC = 8'h94;
    localparam logic [7:0] RSP_GET_VER = 8'h95;
    localparam logic [7:0] RSP_TYPE_FLAG = 8'h80;
    // ----------------------------------------
    // response and reason codes
    // ----------------------------------------
    localparam logic [15:0] RC_OK = 16'h0000;
    localparam logic [15:0] RC_FAIL = 16'h0001;
    localparam logic [15:0] RC_UNSUP = 16'h0003;
    localparam logic [15:0] RS_NONE = 16'h0000;
    localparam logic [15:0] RS_BAD_PARAM = 16'h0002;
    localparam logic [15:0] RS_FC_INDEP = 16'h1409;
    localparam logic [15:0] RS_UNKNOWN = 16'h7fff;
    // ----------------------------------------
    // flow control enable values and package address
    // ----------------------------------------
    localparam logic [7:0] FC_OFF = 8'h00;
    localparam logic [7:0] FC_GEN = 8'h01;
    localparam logic [7:0] FC_ACC = 8'h02;
    localparam logic [7:0] FC_BOTH = 8'h03;
    localparam logic [4:0] CHAN_PKG = 5'h1f;
    // ----------------------------------------
    // register offsets and fields
    // ----------------------------------------
    localparam logic [7:0] ADDR_CMD = 8'h00;
    localparam logic [7:0] ADDR_RESP = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_VERSION = 8'h0c;
    localparam logic [7:0] ADDR_FW = 8'h10;
    localparam int CMD_CODE_LSB = 0;
    localparam int CMD_FCE_LSB = 8;
    localparam int CMD_CHAN_LSB = 16;
    localparam int CMD_CKERR_BIT = 24;
    localparam int CMD_IDERR_BIT = 25;
    localparam int ST_RVALID_BIT = 0;
    localparam int ST_MCALL_BIT = 1;
    localparam int ST_FCMODE_LSB = 2;
    localparam int ST_PAUSE_BIT = 4;
    localparam int ST_RTYPE_LSB = 8;
    localparam int ST_CHREQ_LSB = 16;
    localparam logic MCALL_RST = 1'b0;
    localparam logic [1:0] FC_RST = 2'b00;
    localparam logic [1:0] AXI_OKAY = 2'b00;
    localparam logic [1:0] AXI_SLVERR = 2'b10;
    // ----------------------------------------
    // timing
    // ----------------------------------------
    localparam int CLK_PERIOD_NS = 10;
    localparam int PAUSE_INTERVAL_US = 1000;
    localparam int PAUSE_INTERVAL_CYC = PAUSE_INTERVAL_US * 1000 / CLK_PERIOD_NS;
    typedef enum logic [1:0] {CONG_IDLE, CONG_REQ, CONG_HOLD} smfc_cong_t;
endpackage : smfc_pkg
`default_nettype wire

// ---- smfc_top.sv ----
// sideband multicast filter and package flow control command handling
//
// The AXI4-Lite slave port and the address map were chosen for this implementation.
`timescale 1ns/10ps
`default_nettype none

module smfc_top #(
    parameter int NUM_CH = 4,
    parameter int unsigned PAUSE_INTERVAL_CYCLES = smfc_pkg::PAUSE_INTERVAL_CYC,
    parameter bit ACCEPT_ALL_MCAST = 1'b1,
    parameter bit FC_OPTIONAL = 1'b1,
    parameter bit FC_INDEPENDENT = 1'b1,
    // arbitrary values
    parameter logic [31:0] VERSION_WORD = 32'h0000_0000,
    parameter logic [31:0] FW_VERSION = 32'h0000_0000
) (
    input wire logic clk_i,
    input wire logic sys_rst_i,
    input wire logic [7:0] s_axi_awaddr_i,
    input wire logic s_axi_awvalid_i,
    output logic s_axi_awready_o,
    input wire logic [31:0] s_axi_wdata_i,
    input wire logic [3:0] s_axi_wstrb_i,
    input wire logic s_axi_wvalid_i,
    output logic s_axi_wready_o,
    output logic [1:0] s_axi_bresp_o,
    output logic s_axi_bvalid_o,
    input wire logic s_axi_bready_i,
    input wire logic [7:0] s_axi_araddr_i,
    input wire logic s_axi_arvalid_i,
    output logic s_axi_arready_o,
    output logic [31:0] s_axi_rdata_o,
    output logic [1:0] s_axi_rresp_o,
    output logic s_axi_rvalid_o,
    input wire logic s_axi_rready_i,
    input wire logic frame_valid_i,
    input wire logic frame_mcast_i,
    input wire logic filter_hit_i,
    output logic frame_fwd_o,
    output logic frame_fwd_valid_o,
    input wire logic [NUM_CH-1:0] chan_congested_i,
    output logic pause_gen_o,
    output logic pause_accept_en_o
);
    if (NUM_CH < 1 || NUM_CH > 16 || PAUSE_INTERVAL_CYCLES < 1)
    begin : g_bad_param
        $error("smfc_top: unsupported parameter values");
    end

    // ----------------------------------------
    // register bus
    // ----------------------------------------
    logic wr_en;
    logic rd_en;
    logic full_strobe;
    logic [31:0] rd_word;
    logic rd_err;
    logic wr_err;
    logic mcast_all;
    logic [1:0] fc_mode;
    logic [31:0] last_cmd;
    logic [15:0] resp_code;
    logic [15:0] resp_reason;
    logic [7:0] resp_type;
    logic resp_valid;
    logic [NUM_CH-1:0] chan_req;

    // both channels are taken together; a half-offered write just waits
    assign wr_en = s_axi_awready_o && s_axi_awvalid_i;
    assign rd_en = s_axi_arready_o && s_axi_arvalid_i;
    assign full_strobe = (s_axi_wstrb_i == 4'hf);

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            s_axi_awready_o <= 1'b0;
            s_axi_wready_o <= 1'b0;
        end
        else
        begin
            s_axi_awready_o <= !s_axi_awready_o && s_axi_awvalid_i && s_axi_wvalid_i && !s_axi_bvalid_o;
            s_axi_wready_o <= !s_axi_awready_o && s_axi_awvalid_i && s_axi_wvalid_i && !s_axi_bvalid_o;
        end
    end

    always_comb
    begin
        wr_err = 1'b1;
        case (s_axi_awaddr_i)
            smfc_pkg::ADDR_CMD, smfc_pkg::ADDR_STATUS: wr_err = 1'b0;
            default: wr_err = 1'b1;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            s_axi_bvalid_o <= 1'b0;
            s_axi_bresp_o <= smfc_pkg::AXI_OKAY;
        end
        else if (wr_en)
        begin
            s_axi_bvalid_o <= 1'b1;
            s_axi_bresp_o <= wr_err ? smfc_pkg::AXI_SLVERR : smfc_pkg::AXI_OKAY;
        end
        else if (s_axi_bready_i)
        begin
            s_axi_bvalid_o <= 1'b0;
        end
    end

    always_comb
    begin
        rd_word = 32'h0000_0000;
        rd_err = 1'b0;
        case (s_axi_araddr_i)
            smfc_pkg::ADDR_CMD: rd_word = last_cmd;
            smfc_pkg::ADDR_RESP: rd_word = {resp_code, resp_reason};
            smfc_pkg::ADDR_STATUS:
            begin
                rd_word[smfc_pkg::ST_RVALID_BIT] = resp_valid;
                rd_word[smfc_pkg::ST_MCALL_BIT] = mcast_all;
                rd_word[smfc_pkg::ST_FCMODE_LSB +: 2] = fc_mode;
                rd_word[smfc_pkg::ST_PAUSE_BIT] = pause_gen_o;
                rd_word[smfc_pkg::ST_RTYPE_LSB +: 8] = resp_type;
                rd_word[smfc_pkg::ST_CHREQ_LSB +: NUM_CH] = chan_req;
            end
            smfc_pkg::ADDR_VERSION: rd_word = VERSION_WORD;
            smfc_pkg::ADDR_FW: rd_word = FW_VERSION;
            default: rd_err = 1'b1;
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            s_axi_arready_o <= 1'b0;
            s_axi_rvalid_o <= 1'b0;
            s_axi_rdata_o <= 32'h0000_0000;
            s_axi_rresp_o <= smfc_pkg::AXI_OKAY;
        end
        else
        begin
            s_axi_arready_o <= !s_axi_arready_o && s_axi_arvalid_i && !s_axi_rvalid_o;
            if (rd_en)
            begin
                s_axi_rvalid_o <= 1'b1;
                s_axi_rdata_o <= rd_word;
                s_axi_rresp_o <= rd_err ? smfc_pkg::AXI_SLVERR : smfc_pkg::AXI_OKAY;
            end
            else if (s_axi_rready_i)
            begin
                s_axi_rvalid_o <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // command decode
    // ----------------------------------------
    logic cmd_wr;
    logic cmd_go;
    logic [7:0] cmd_code;
    logic [7:0] cmd_fce;
    logic next_respond;
    logic [15:0] next_resp_code;
    logic [15:0] next_reason;
    logic [7:0] next_type;
    logic next_mcast_all;
    logic [1:0] next_fc_mode;

    assign cmd_wr = wr_en && full_strobe && (s_axi_awaddr_i == smfc_pkg::ADDR_CMD);
    assign cmd_code = s_axi_wdata_i[smfc_pkg::CMD_CODE_LSB +: 8];
    assign cmd_fce = s_axi_wdata_i[smfc_pkg::CMD_FCE_LSB +: 8];
    // checksum or identifier faults are dropped silently, no response
    assign cmd_go = cmd_wr && !s_axi_wdata_i[smfc_pkg::CMD_CKERR_BIT] && !s_axi_wdata_i[smfc_pkg::CMD_IDERR_BIT];

    always_comb
    begin
        next_respond = cmd_go;
        next_resp_code = smfc_pkg::RC_OK;
        next_reason = smfc_pkg::RS_NONE;
        next_type = cmd_code | smfc_pkg::RSP_TYPE_FLAG;
        next_mcast_all = mcast_all;
        next_fc_mode = fc_mode;
        case (cmd_code)
            smfc_pkg::CMD_EN_GMCAST:
            begin
                next_type = smfc_pkg::RSP_EN_GMCAST;
                if (!ACCEPT_ALL_MCAST)
                begin
                    next_resp_code = smfc_pkg::RC_UNSUP;
                    next_reason = smfc_pkg::RS_UNKNOWN;
                end
                else
                begin
                    next_mcast_all = 1'b0;
                end
            end
            smfc_pkg::CMD_DIS_GMCAST:
            begin
                next_type = smfc_pkg::RSP_DIS_GMCAST;
                if (!ACCEPT_ALL_MCAST)
                begin
                    next_resp_code = smfc_pkg::RC_UNSUP;
                    next_reason = smfc_pkg::RS_UNKNOWN;
                end
                else
                begin
                    next_mcast_all = 1'b1;
                end
            end
            smfc_pkg::CMD_SET_FC:
            begin
                next_type = smfc_pkg::RSP_SET_FC;
                // wrong channel field is a mismatch
                if (s_axi_wdata_i[smfc_pkg::CMD_CHAN_LSB +: 5] != smfc_pkg::CHAN_PKG)
                begin
                    next_respond = 1'b0;
                end
                else if (cmd_fce == smfc_pkg::FC_OFF)
                begin
                    next_fc_mode = 2'(smfc_pkg::FC_OFF);
                end
                else if (cmd_fce > smfc_pkg::FC_BOTH || !FC_OPTIONAL)
                begin
                    next_resp_code = smfc_pkg::RC_FAIL;
                    next_reason = smfc_pkg::RS_BAD_PARAM;
                end
                else if (cmd_fce != smfc_pkg::FC_BOTH && !FC_INDEPENDENT)
                begin
                    next_resp_code = smfc_pkg::RC_FAIL;
                    next_reason = smfc_pkg::RS_FC_INDEP;
                end
                else
                begin
                    next_fc_mode = cmd_fce[1:0];
                end
            end
            smfc_pkg::CMD_GET_VER:
            begin
                next_type = smfc_pkg::RSP_GET_VER;
            end
            default:
            begin
                next_resp_code = smfc_pkg::RC_UNSUP;
                next_reason = smfc_pkg::RS_UNKNOWN;
            end
        endcase
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            mcast_all <= smfc_pkg::MCALL_RST;
            fc_mode <= smfc_pkg::FC_RST;
            last_cmd <= 32'h0000_0000;
        end
        else if (cmd_go && next_respond)
        begin
            mcast_all <= next_mcast_all;
            fc_mode <= next_fc_mode;
            last_cmd <= s_axi_wdata_i;
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            resp_code <= smfc_pkg::RC_OK;
            resp_reason <= smfc_pkg::RS_NONE;
            resp_type <= 8'h00;
        end
        else if (cmd_go && next_respond)
        begin
            resp_code <= next_resp_code;
            resp_reason <= next_reason;
            resp_type <= next_type;
        end
    end

    // a new response wins over a software clear in the same cycle
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            resp_valid <= 1'b0;
        end
        else if (cmd_go && next_respond)
        begin
            resp_valid <= 1'b1;
        end
        else if (wr_en && full_strobe && s_axi_awaddr_i == smfc_pkg::ADDR_STATUS
                 && s_axi_wdata_i[smfc_pkg::ST_RVALID_BIT])
        begin
            resp_valid <= 1'b0;
        end
    end

    // ----------------------------------------
    // multicast forwarding
    // ----------------------------------------
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            frame_fwd_o <= 1'b0;
            frame_fwd_valid_o <= 1'b0;
        end
        else
        begin
            frame_fwd_valid_o <= frame_valid_i;
            // all multicast passes; else filter hits only
            frame_fwd_o <= frame_valid_i && (!frame_mcast_i || mcast_all || filter_hit_i);
        end
    end

    // ----------------------------------------
    // per-channel congestion pause
    // ----------------------------------------
    logic gen_en;
    assign gen_en = fc_mode[0];

    for (genvar g = 0; g < NUM_CH; g++)
    begin : g_ch
        smfc_pkg::smfc_cong_t st;
        logic [31:0] cnt;
        logic last;
        assign last = (cnt == 32'(PAUSE_INTERVAL_CYCLES - 1));
        assign chan_req[g] = (st == smfc_pkg::CONG_REQ);
        always_ff @(posedge clk_i)
        begin
            if (sys_rst_i || !gen_en)
            begin
                st <= smfc_pkg::CONG_IDLE;
                cnt <= 32'h0000_0000;
            end
            else
            begin
                case (st)
                    smfc_pkg::CONG_IDLE:
                    begin
                        cnt <= 32'h0000_0000;
                        if (chan_congested_i[g])
                        begin
                            st <= smfc_pkg::CONG_REQ;
                        end
                    end
                    // request held one interval at most
                    smfc_pkg::CONG_REQ:
                    begin
                        cnt <= last ? 32'h0000_0000 : cnt + 32'h0000_0001;
                        if (!chan_congested_i[g])
                        begin
                            st <= smfc_pkg::CONG_IDLE;
                        end
                        else if (last)
                        begin
                            st <= smfc_pkg::CONG_HOLD;
                        end
                    end
                    // second interval ends in initial state
                    smfc_pkg::CONG_HOLD:
                    begin
                        cnt <= cnt + 32'h0000_0001;
                        if (!chan_congested_i[g] || last)
                        begin
                            st <= smfc_pkg::CONG_IDLE;
                        end
                    end
                    default: st <= smfc_pkg::CONG_IDLE;
                endcase
            end
        end
    end

    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i)
        begin
            pause_gen_o <= 1'b0;
            pause_accept_en_o <= 1'b0;
        end
        else
        begin
            pause_gen_o <= |chan_req;
            pause_accept_en_o <= fc_mode[1];
        end
    end

    // ----------------------------------------
    // checks
    // ----------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (sys_rst_i);

    logic [31:0] req_run0;
    always_ff @(posedge clk_i)
    begin
        if (sys_rst_i || !chan_req[0])
        begin
            req_run0 <= 32'h0000_0000;
        end
        else
        begin
            req_run0 <= req_run0 + 32'h0000_0001;
        end
    end

    chk_en_filter_resp: assert property ((cmd_go && cmd_code == 8'h12 && ACCEPT_ALL_MCAST)
        |=> resp_valid && resp_type == 8'h92 && resp_reason == 16'h0000 && !mcast_all)
        else $error("enable filter response wrong");
    chk_resp_word_read: assert property ((rd_en && s_axi_araddr_i == smfc_pkg::ADDR_RESP)
        |=> s_axi_rvalid_o && s_axi_rdata_o == {$past(resp_code), $past(resp_reason)})
        else $error("response word read wrong");
    chk_all_mcast_pass: assert property ((mcast_all && frame_valid_i && frame_mcast_i)
        |=> frame_fwd_o && frame_fwd_valid_o)
        else $error("multicast frame not forwarded");
    chk_mcast_unsupported: assert property ((cmd_go && cmd_code == 8'h13 && !ACCEPT_ALL_MCAST)
        |=> resp_code == smfc_pkg::RC_UNSUP && mcast_all == $past(mcast_all))
        else $error("global multicast taken without support");
    chk_filter_reject: assert property ((!mcast_all && frame_valid_i && frame_mcast_i && !filter_hit_i)
        |=> !frame_fwd_o)
        else $error("unfiltered multicast forwarded");
    chk_dis_filter_resp: assert property ((cmd_go && cmd_code == 8'h13 && ACCEPT_ALL_MCAST)
        |=> resp_type == 8'h93 && resp_code == 16'h0000 && mcast_all)
        else $error("disable filter response wrong");
    chk_pause_run_bound: assert property (req_run0 <= PAUSE_INTERVAL_CYCLES)
        else $error("pause request longer than interval");
    chk_hold_to_idle: assert property ((g_ch[0].st == smfc_pkg::CONG_HOLD && g_ch[0].last)
        |=> g_ch[0].st == smfc_pkg::CONG_IDLE && !chan_req[0])
        else $error("channel not back to initial state");
    chk_pause_any_chan: assert property ((|chan_req) |=> pause_gen_o)
        else $error("pause dropped while a channel requests");
    chk_fc_zero_off: assert property ((cmd_go && cmd_code == 8'h14 && cmd_fce == 8'h00
        && s_axi_wdata_i[smfc_pkg::CMD_CHAN_LSB +: 5] == 5'h1f) |=> fc_mode == 2'b00 ##2 !pause_gen_o)
        else $error("zero enable did not stop pause");
    chk_fc_resp_type: assert property ((cmd_go && cmd_code == 8'h14
        && s_axi_wdata_i[smfc_pkg::CMD_CHAN_LSB +: 5] == 5'h1f) |=> resp_valid && resp_type == 8'h94)
        else $error("flow control response wrong");
    chk_fc_indep_reason: assert property ((cmd_go && cmd_code == 8'h14 && cmd_fce == 8'h01
        && FC_OPTIONAL && !FC_INDEPENDENT && s_axi_wdata_i[smfc_pkg::CMD_CHAN_LSB +: 5] == 5'h1f)
        |=> resp_reason == 16'h1409 && fc_mode == $past(fc_mode))
        else $error("one-direction request not refused");
    chk_version_resp: assert property ((cmd_go && cmd_code == 8'h15)
        |=> resp_valid && resp_type == 8'h95 && resp_code == 16'h0000)
        else $error("version response wrong");
    chk_fc_reserved_kept: assert property ((cmd_go && cmd_code == 8'h14 && cmd_fce > 8'h03)
        |=> fc_mode == $past(fc_mode) && (!resp_valid || resp_code == smfc_pkg::RC_FAIL || !$past(next_respond)))
        else $error("reserved enable changed setting");

    cov_pause_on: cover property (!pause_gen_o ##1 pause_gen_o);
    cov_hold_expiry: cover property (g_ch[0].st == smfc_pkg::CONG_HOLD && g_ch[0].last);
    cov_mcast_all: cover property (cmd_go && cmd_code == smfc_pkg::CMD_DIS_GMCAST ##1 mcast_all);
    cov_read_resp: cover property (rd_en && s_axi_araddr_i == smfc_pkg::ADDR_RESP);
endmodule : smfc_top

`default_nettype wire

// ---- smfc_frame_src.sv ----
// frame source model standing on the network side of the block
`timescale 1ns/10ps
`default_nettype none
module smfc_frame_src (
    input wire logic clk_i,
    output logic frame_valid_o,
    output logic frame_mcast_o,
    output logic filter_hit_o
);
    initial
    begin
        frame_valid_o = 1'b0;
        frame_mcast_o = 1'b0;
        filter_hit_o = 1'b0;
    end
    // one frame, one cycle; qualifiers flip afterwards so stale levels are never trusted
    task automatic send(input logic m, input logic h);
        @(posedge clk_i);
        frame_valid_o <= 1'b1;
        frame_mcast_o <= m;
        filter_hit_o <= h;
        @(posedge clk_i);
        frame_valid_o <= 1'b0;
        frame_mcast_o <= ~m;
        filter_hit_o <= ~h;
    endtask : send
endmodule : smfc_frame_src
`default_nettype wire

// ---- sideband_mcast_flowctl_commands_tb.sv ----
// self-checking testbench for the sideband command block
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin n_fail++; $display("[FAIL] %0t got %h exp %h", $time, a, e); end end
module sideband_mcast_flowctl_commands_tb;
    logic clk_i = 1'b0;
    logic sys_rst_i = 1'b1;
    logic [7:0] s_axi_awaddr_i = 8'h00, s_axi_araddr_i = 8'h00;
    logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o, rd, alt_rdata, rd_alt;
    logic [3:0] s_axi_wstrb_i = 4'hf, chan_congested_i = 4'h0;
    logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0, s_axi_bready_i = 1'b0;
    logic s_axi_arvalid_i = 1'b0, s_axi_rready_i = 1'b0;
    logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
    logic [1:0] s_axi_bresp_o, s_axi_rresp_o, rr;
    logic frame_valid_i, frame_mcast_i, filter_hit_i, frame_fwd_o, frame_fwd_valid_o;
    logic pause_gen_o, pause_accept_en_o;
    int n_fail = 0;
    int samples_checked = 0;
    int n;
    always #5 clk_i = ~clk_i;
    smfc_frame_src i_host (.clk_i, .frame_valid_o(frame_valid_i), .frame_mcast_o(frame_mcast_i),
        .filter_hit_o(filter_hit_i));
    smfc_top #(.PAUSE_INTERVAL_CYCLES(8)) i_dut (.clk_i, .sys_rst_i, .s_axi_awaddr_i, .s_axi_awvalid_i,
        .s_axi_awready_o, .s_axi_wdata_i, .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o,
        .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
        .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .frame_valid_i, .frame_mcast_i, .filter_hit_i,
        .frame_fwd_o, .frame_fwd_valid_o, .chan_congested_i, .pause_gen_o, .pause_accept_en_o);
    // twin without accept-all and with tied directions; same stimulus, so its bus timing matches
    smfc_top #(.PAUSE_INTERVAL_CYCLES(8), .ACCEPT_ALL_MCAST(1'b0), .FC_INDEPENDENT(1'b0)) i_dut_alt (.clk_i,
        .sys_rst_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o(), .s_axi_wdata_i, .s_axi_wstrb_i,
        .s_axi_wvalid_i, .s_axi_wready_o(), .s_axi_bresp_o(), .s_axi_bvalid_o(), .s_axi_bready_i,
        .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o(), .s_axi_rdata_o(alt_rdata), .s_axi_rresp_o(),
        .s_axi_rvalid_o(), .s_axi_rready_i, .frame_valid_i, .frame_mcast_i, .filter_hit_i, .frame_fwd_o(),
        .frame_fwd_valid_o(), .chan_congested_i, .pause_gen_o(), .pause_accept_en_o());
    // ----------------------------------------
    // bus tasks
    // ----------------------------------------
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_i);
        s_axi_awaddr_i <= a;
        s_axi_wdata_i <= d;
        s_axi_awvalid_i <= 1'b1;
        s_axi_wvalid_i <= 1'b1;
        s_axi_bready_i <= 1'b1;
        do @(posedge clk_i); while (s_axi_awready_o !== 1'b1);
        s_axi_awvalid_i <= 1'b0;
        s_axi_wvalid_i <= 1'b0;
        do @(posedge clk_i); while (s_axi_bvalid_o !== 1'b1);
        rr = s_axi_bresp_o;
        s_axi_bready_i <= 1'b0;
    endtask : wr
    task automatic rdr(input logic [7:0] a);
        @(posedge clk_i);
        s_axi_araddr_i <= a;
        s_axi_arvalid_i <= 1'b1;
        s_axi_rready_i <= 1'b1;
        do @(posedge clk_i); while (s_axi_arready_o !== 1'b1);
        s_axi_arvalid_i <= 1'b0;
        do @(posedge clk_i); while (s_axi_rvalid_o !== 1'b1);
        rd = s_axi_rdata_o;
        rd_alt = alt_rdata;
        rr = s_axi_rresp_o;
        s_axi_rready_i <= 1'b0;
    endtask : rdr
    task automatic fr(input logic m, input logic h, input logic e);
        i_host.send(m, h);
        #1;
        `CHK({frame_fwd_valid_o, frame_fwd_o}, {1'b1, e})
    endtask : fr
    // congestion burst: ch0 at start, mask c2 from the third edge, 16 edges sampled
    task automatic burst(input logic [3:0] c2);
        @(posedge clk_i);
        chan_congested_i <= 4'h1;
        n = 0;
        for (int i = 1; i <= 16; i++)
        begin
            @(posedge clk_i);
            if (i == 3)
                chan_congested_i <= c2;
            if (pause_gen_o === 1'b1)
                n++;
        end
        chan_congested_i <= 4'h0;
        repeat (3) @(posedge clk_i);
    endtask : burst
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    task automatic t_mcast();
        fr(1'b1, 1'b0, 1'b0);
        fr(1'b1, 1'b1, 1'b1);
        wr(smfc_pkg::ADDR_CMD, {24'h0, smfc_pkg::CMD_DIS_GMCAST});
        rdr(smfc_pkg::ADDR_RESP);
        `CHK(rd, 32'h0)
        `CHK(rd_alt, {smfc_pkg::RC_UNSUP, smfc_pkg::RS_UNKNOWN})
        rdr(smfc_pkg::ADDR_STATUS);
        `CHK(rd[15:0], {smfc_pkg::RSP_DIS_GMCAST, 8'h03})
        fr(1'b1, 1'b0, 1'b1);
        fr(1'b0, 1'b0, 1'b1);
        wr(smfc_pkg::ADDR_CMD, {24'h0, smfc_pkg::CMD_EN_GMCAST});
        rdr(smfc_pkg::ADDR_STATUS);
        `CHK(rd[15:0], {smfc_pkg::RSP_EN_GMCAST, 8'h01})
        fr(1'b1, 1'b0, 1'b0);
        $display("mcast test done");
    endtask : t_mcast
    task automatic t_fc();
        logic [1:0] m;
        for (int v = 0; v < 5; v++)
        begin
            m = (v < 4) ? v[1:0] : 2'h3;
            wr(smfc_pkg::ADDR_CMD, {11'h0, smfc_pkg::CHAN_PKG, v[7:0], smfc_pkg::CMD_SET_FC});
            rdr(smfc_pkg::ADDR_RESP);
            `CHK(rd, (v < 4) ? 32'h0 : {smfc_pkg::RC_FAIL, smfc_pkg::RS_BAD_PARAM})
            if (v == 1 || v == 2)
                `CHK(rd_alt, {smfc_pkg::RC_FAIL, smfc_pkg::RS_FC_INDEP})
            rdr(smfc_pkg::ADDR_STATUS);
            `CHK(rd[15:2], {smfc_pkg::RSP_SET_FC, 4'h0, m})
            `CHK(pause_accept_en_o, m[1])
        end
        wr(smfc_pkg::ADDR_STATUS, 32'h1);
        wr(smfc_pkg::ADDR_CMD, {16'h0, smfc_pkg::CMD_SET_FC});
        rdr(smfc_pkg::ADDR_STATUS);
        `CHK(rd[3:0], 4'hc)
        $display("flow control test done");
    endtask : t_fc
    task automatic t_cong();
        wr(smfc_pkg::ADDR_CMD, {11'h0, smfc_pkg::CHAN_PKG, smfc_pkg::FC_GEN, smfc_pkg::CMD_SET_FC});
        burst(4'h1);
        `CHK(n, 8)
        burst(4'h3);
        `CHK(n, 11)
        `CHK(pause_gen_o, 1'b0)
        $display("congestion test done");
    endtask : t_cong
    task automatic t_misc();
        // header-only version request
        wr(smfc_pkg::ADDR_CMD, {24'h0, smfc_pkg::CMD_GET_VER});
        rdr(smfc_pkg::ADDR_STATUS);
        `CHK(rd[15:8], smfc_pkg::RSP_GET_VER)
        rdr(smfc_pkg::ADDR_RESP);
        `CHK(rd, 32'h0)
        // checksum fault: command dropped, last accepted word kept
        wr(smfc_pkg::ADDR_CMD, {7'h0, 1'b1, 16'h0, smfc_pkg::CMD_DIS_GMCAST});
        rdr(smfc_pkg::ADDR_CMD);
        `CHK(rd, {24'h0, smfc_pkg::CMD_GET_VER})
        wr(smfc_pkg::ADDR_CMD, {24'h0, 8'h7e});
        rdr(smfc_pkg::ADDR_RESP);
        `CHK(rd, {smfc_pkg::RC_UNSUP, smfc_pkg::RS_UNKNOWN})
        wr(smfc_pkg::ADDR_RESP, 32'h0);
        `CHK(rr, smfc_pkg::AXI_SLVERR)
        rdr(8'h40);
        `CHK(rr, smfc_pkg::AXI_SLVERR)
        // mid-run reset turns filtering on (accept-all cleared) and flow control off
        sys_rst_i <= 1'b1;
        repeat (2) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        rdr(smfc_pkg::ADDR_STATUS);
        `CHK(rd, 32'h0)
        $display("misc test done");
    endtask : t_misc
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", samples_checked, n_fail);
        if (n_fail == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : tally_and_finish
    initial
    begin
        #400000;
        n_fail++;
        tally_and_finish();
    end
    initial
    begin
        repeat (8) @(posedge clk_i);
        sys_rst_i <= 1'b0;
        rdr(smfc_pkg::ADDR_STATUS);
        `CHK(rd, 32'h0)
        t_mcast();
        t_fc();
        t_cong();
        t_misc();
        tally_and_finish();
    end
endmodule : sideband_mcast_flowctl_commands_tb
`default_nettype wire
